/* File: design/brd_boot_remap_decoder.sv */
// Functional notes
// - SRAM is always decoded at its base region; only there before remap.
// - After remap SRAM is also aliased at address zero.
// - ROM is decoded at its fixed base region at all times.
// - Flash is decoded at its fixed base region at all times.
// - Before remap, Flash appears at address zero when boot-select bit is set.
// - Boot-select bit chooses ROM or Flash boot; ROM is the default.
// - Boot-select bit changes only by flash controller set and clear commands, the erase input or power-on reset.
// - Erase input clears the boot-select bit, falling back to ROM boot.
// - Peripheral region spans 0xF0000000 to 0xFFFFEFFF.
// - Each peripheral gets its own 16 Kbyte slot.
// - SRAM window matches fitted bank size of 32, 64 or 128 Kbyte.
// - Dual-plane variant decodes two 256 Kbyte Flash banks.
// - Single-plane Flash window matches 256 or 128 Kbyte bank.
`timescale 1ns/1ps
module brd_boot_remap_decoder
  import brd_pkg::*;
#(
  parameter int SRAM_KB = BRD_SRAM_KB_DEF,
  parameter int FLASH_BANK_KB = BRD_FLASH_BANK_KB_DEF,
  parameter int FLASH_BANKS = BRD_FLASH_BANKS_DEF
) (
  // Clock, resets, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic porRst,
  input wire logic ce,
  // Address request
  input wire logic reqValid,
  input wire logic [31:0] reqAddr,
  // Remap and boot-select commands
  input wire logic remapCmd,
  input wire logic bootSelSetCmd,
  input wire logic bootSelClrCmd,
  input wire logic erasePin,
  // Route and state out
  output brd_route_s route,
  output logic remapped,
  output logic bootFromFlash
);

  localparam int SRAM_LOG2 = $clog2(SRAM_KB * 1024);
  localparam int BANK_LOG2 = $clog2(FLASH_BANK_KB * 1024);
  localparam int FLASH_LOG2 = BANK_LOG2 + ((FLASH_BANKS == 2) ? 1 : 0);

  generate
    if (!(SRAM_KB == 32 || SRAM_KB == 64 || SRAM_KB == 128))
    begin : g_bad_sram
      $error("brd_boot_remap_decoder: SRAM_KB must be 32, 64 or 128");
    end
    if (!(FLASH_BANK_KB == 128 || FLASH_BANK_KB == 256))
    begin : g_bad_bank
      $error("brd_boot_remap_decoder: FLASH_BANK_KB must be 128 or 256");
    end
    if (!(FLASH_BANKS == 1 || (FLASH_BANKS == 2 && FLASH_BANK_KB == 256)))
    begin : g_bad_banks
      $error("brd_boot_remap_decoder: FLASH_BANKS must be 1, or 2 with 256 Kbyte banks");
    end
  endgenerate

  logic remap_q;
  logic bootSel_q;
  logic eraseMeta_q;
  logic eraseSync_q;
  brd_route_s route_q;
  brd_route_s route_d;

  logic sramHit, romHit, flashHit, sramZHit, romZHit, flashZHit, periphHit;
  logic [31:0] sramOff, romOff, flashOff, sramZOff, romZOff, flashZOff;

  // Fixed and zero-alias windows
  brd_region_match #(.BASE(BRD_SRAM_BASE), .SIZE_LOG2(SRAM_LOG2)) u_sram (
    .addr(reqAddr), .hit(sramHit), .offset(sramOff));
  brd_region_match #(.BASE(BRD_ROM_BASE), .SIZE_LOG2(BRD_ROM_LOG2)) u_rom (
    .addr(reqAddr), .hit(romHit), .offset(romOff));
  brd_region_match #(.BASE(BRD_FLASH_BASE), .SIZE_LOG2(FLASH_LOG2)) u_flash (
    .addr(reqAddr), .hit(flashHit), .offset(flashOff));
  brd_region_match #(.BASE(BRD_ZERO_BASE), .SIZE_LOG2(SRAM_LOG2)) u_sram_z (
    .addr(reqAddr), .hit(sramZHit), .offset(sramZOff));
  brd_region_match #(.BASE(BRD_ZERO_BASE), .SIZE_LOG2(BRD_ROM_LOG2)) u_rom_z (
    .addr(reqAddr), .hit(romZHit), .offset(romZOff));
  brd_region_match #(.BASE(BRD_ZERO_BASE), .SIZE_LOG2(FLASH_LOG2)) u_flash_z (
    .addr(reqAddr), .hit(flashZHit), .offset(flashZOff));

  // Peripheral span
  assign periphHit = (reqAddr >= BRD_PERIPH_LO) && (reqAddr <= BRD_PERIPH_HI);

  // Erase pin synchroniser
  always_ff @(posedge sys_clk)
  begin
    if (porRst)
    begin
      eraseMeta_q <= 1'b0;
      eraseSync_q <= 1'b0;
    end
    else if (ce)
    begin
      eraseMeta_q <= erasePin;
      eraseSync_q <= eraseMeta_q;
    end
  end

  // Non-volatile boot select, kept across rst
  always_ff @(posedge sys_clk)
  begin
    if (porRst)
      bootSel_q <= BRD_BOOT_SEL_RST;
    else if (ce)
    begin
      if (eraseSync_q)
        bootSel_q <= 1'b0;
      else if (bootSelSetCmd)
        bootSel_q <= 1'b1;
      else if (bootSelClrCmd)
        bootSel_q <= 1'b0;
    end
  end

  // Remap latch, cleared only by reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      remap_q <= 1'b0;
    else if (ce && remapCmd)
      remap_q <= 1'b1;
  end

  // Route decode
  always_comb
  begin
    route_d = '0;
    route_d.valid = reqValid;
    route_d.target = TGT_NONE;
    if (sramHit)
    begin
      route_d.target = TGT_SRAM;
      route_d.offset = sramOff;
    end
    else if (romHit)
    begin
      route_d.target = TGT_ROM;
      route_d.offset = romOff;
    end
    else if (flashHit)
    begin
      route_d.target = TGT_FLASH;
      route_d.offset = flashOff;
    end
    else if (periphHit)
    begin
      route_d.target = TGT_PERIPH;
      route_d.slot = reqAddr[BRD_SLOT_LOG2 +: BRD_SLOT_W];
      route_d.offset = {{(32 - BRD_SLOT_LOG2){1'b0}}, reqAddr[BRD_SLOT_LOG2-1:0]};
    end
    else if (remap_q && sramZHit)
    begin
      route_d.target = TGT_SRAM;
      route_d.offset = sramZOff;
    end
    else if (!remap_q && bootSel_q && flashZHit)
    begin
      route_d.target = TGT_FLASH;
      route_d.offset = flashZOff;
    end
    else if (!remap_q && !bootSel_q && romZHit)
    begin
      route_d.target = TGT_ROM;
      route_d.offset = romZOff;
    end
    if (route_d.target == TGT_FLASH && FLASH_BANKS == 2)
      route_d.flashBank = route_d.offset[BANK_LOG2];
  end

  // Registered route
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      route_q <= '0;
    else if (ce)
      route_q <= route_d;
  end

  assign route = route_q;
  assign remapped = remap_q;
  assign bootFromFlash = bootSel_q;

  // Checks
  property p_sram_base;
    @(posedge sys_clk) disable iff (rst)
    (ce && reqAddr >= BRD_SRAM_BASE && reqAddr < BRD_SRAM_BASE + SRAM_KB * 1024)
      |=> (route.target == TGT_SRAM && route.offset == $past(reqAddr) - BRD_SRAM_BASE);
  endproperty
  a_sram_base: assert property (p_sram_base) else $error("SRAM base not routed to SRAM");

  property p_sram_alias;
    @(posedge sys_clk) disable iff (rst)
    (ce && remap_q && reqAddr < SRAM_KB * 1024) |=> (route.target == TGT_SRAM);
  endproperty
  a_sram_alias: assert property (p_sram_alias) else $error("SRAM not aliased at zero after remap");

  property p_rom_base;
    @(posedge sys_clk) disable iff (rst)
    (ce && reqAddr[31:BRD_ROM_LOG2] == 12'h003) |=> (route.target == TGT_ROM);
  endproperty
  a_rom_base: assert property (p_rom_base) else $error("ROM base not routed to ROM");

  property p_flash_base;
    @(posedge sys_clk) disable iff (rst)
    (ce && reqAddr >= BRD_FLASH_BASE && reqAddr < BRD_FLASH_BASE + FLASH_BANKS * FLASH_BANK_KB * 1024)
      |=> (route.target == TGT_FLASH);
  endproperty
  a_flash_base: assert property (p_flash_base) else $error("Flash base not routed to Flash");

  property p_flash_zero;
    @(posedge sys_clk) disable iff (rst || porRst)
    (ce && !remap_q && bootSel_q && reqAddr < FLASH_BANKS * FLASH_BANK_KB * 1024)
      |=> (route.target == TGT_FLASH);
  endproperty
  a_flash_zero: assert property (p_flash_zero) else $error("Flash not at zero with boot select set");

  property p_rom_zero;
    @(posedge sys_clk) disable iff (rst || porRst)
    (ce && !remap_q && !bootSel_q && reqAddr < 32'h0010_0000) |=> (route.target == TGT_ROM);
  endproperty
  a_rom_zero: assert property (p_rom_zero) else $error("ROM not at zero with boot select clear");

  property p_erase_clears;
    @(posedge sys_clk) disable iff (porRst)
    (ce && eraseSync_q) |=> !bootSel_q;
  endproperty
  a_erase_clears: assert property (p_erase_clears) else $error("Erase did not clear boot select");

  property p_boot_cmd_only;
    @(posedge sys_clk) disable iff (porRst)
    (bootSel_q != $past(bootSel_q)) |-> $past(ce && (bootSelSetCmd || bootSelClrCmd || eraseSync_q));
  endproperty
  a_boot_cmd_only: assert property (p_boot_cmd_only) else $error("Boot select changed without command");

  property p_remap_hold;
    @(posedge sys_clk) disable iff (rst)
    remap_q |=> remap_q;
  endproperty
  a_remap_hold: assert property (p_remap_hold) else $error("Remap state lost before reset");

  property p_periph_slot;
    @(posedge sys_clk) disable iff (rst)
    (ce && reqAddr >= BRD_PERIPH_LO && reqAddr <= BRD_PERIPH_HI)
      |=> (route.target == TGT_PERIPH && route.slot == $past(reqAddr[27:14]));
  endproperty
  a_periph_slot: assert property (p_periph_slot) else $error("Peripheral slot decode wrong");

  property p_periph_edge;
    @(posedge sys_clk) disable iff (rst)
    (ce && reqAddr > BRD_PERIPH_HI) |=> (route.target == TGT_NONE);
  endproperty
  a_periph_edge: assert property (p_periph_edge) else $error("Address above peripheral span decoded");

  property p_ce_freeze;
    @(posedge sys_clk) disable iff (rst || porRst)
    !ce |=> ($stable(route) && $stable(remap_q) && $stable(bootSel_q));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("State moved while clock enable low");

endmodule : brd_boot_remap_decoder

/* File: design/brd_region_match.sv */
`timescale 1ns/1ps
module brd_region_match #(
  parameter logic [31:0] BASE = 32'h0000_0000,
  parameter int SIZE_LOG2 = 16
) (
  // Address in
  input wire logic [31:0] addr,
  // Match out
  output logic hit,
  output logic [31:0] offset
);

  localparam logic [31:0] MASK = 32'((64'h1 << SIZE_LOG2) - 64'h1);

  generate
    if (SIZE_LOG2 < 1 || SIZE_LOG2 > 31)
    begin : g_bad
      $error("brd_region_match: SIZE_LOG2 out of range");
    end
    if ((BASE & MASK) != 32'h0000_0000)
    begin : g_align
      $error("brd_region_match: BASE not aligned to window");
    end
  endgenerate

  // Aligned window compare
  assign hit = (addr & ~MASK) == BASE;
  assign offset = addr & MASK;

endmodule : brd_region_match

/* File: include/brd_pkg.sv */
package brd_pkg;

  // Fixed base addresses of the on-chip map
  localparam logic [31:0] BRD_ZERO_BASE = 32'h0000_0000;
  localparam logic [31:0] BRD_FLASH_BASE = 32'h0010_0000;
  localparam logic [31:0] BRD_SRAM_BASE = 32'h0020_0000;
  localparam logic [31:0] BRD_ROM_BASE = 32'h0030_0000;
  localparam logic [31:0] BRD_PERIPH_LO = 32'hF000_0000;
  localparam logic [31:0] BRD_PERIPH_HI = 32'hFFFF_EFFF;

  // Window sizes
  localparam int BRD_ROM_LOG2 = 20;
  localparam int BRD_SLOT_LOG2 = 14;
  localparam int BRD_SLOT_W = 14;
  localparam int BRD_SRAM_KB_DEF = 64;
  localparam int BRD_FLASH_BANK_KB_DEF = 256;
  localparam int BRD_FLASH_BANKS_DEF = 1;

  // Boot-select bit index and its reset value (ROM boot)
  localparam int BRD_BOOT_SEL_IDX = 2;
  localparam logic BRD_BOOT_SEL_RST = 1'b0;

  // Remap control register offset in the memory controller
  localparam logic [7:0] BRD_REMAP_CTRL_OFFSET = 8'h00;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_SRAM,
    TGT_ROM,
    TGT_FLASH,
    TGT_PERIPH
  } brd_target_e;

  typedef struct packed {
    logic valid;
    brd_target_e target;
    logic [31:0] offset;
    logic [BRD_SLOT_W-1:0] slot;
    logic flashBank;
  } brd_route_s;

endpackage : brd_pkg

/* File: testbench/brd_bus_master.sv */
`timescale 1ns/1ps
module brd_bus_master
  import brd_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Address request and remap write
  output logic reqValid,
  output logic [31:0] reqAddr,
  output logic remapCmd
);
  logic [31:0] lastAddr = 32'h0000_0000;

  initial
  begin
    reqValid = 1'b0;
    reqAddr = 32'h0000_0000;
    remapCmd = 1'b0;
  end

  // Address held from launch edge to sampling edge
  task automatic read(input logic [31:0] a);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqAddr <= a;
    lastAddr = a;
    @(posedge sys_clk);
  endtask : read

  // Released bus shows inverted last address
  task automatic release_bus();
    @(posedge sys_clk);
    reqValid <= 1'b0;
    reqAddr <= ~lastAddr;
    @(posedge sys_clk);
  endtask : release_bus

  // Memory controller write, remap at offset zero
  task automatic mc_write(input logic [7:0] off);
    @(posedge sys_clk);
    if (off == BRD_REMAP_CTRL_OFFSET) remapCmd <= 1'b1;
    @(posedge sys_clk);
    remapCmd <= 1'b0;
  endtask : mc_write
endmodule : brd_bus_master

/* File: testbench/tb_brd_boot_remap_decoder.sv */
`timescale 1ns/1ps
module tb_brd_boot_remap_decoder
  import brd_pkg::*;
;
  localparam int SRAM_KB = 64;
  localparam int FL_KB = 256;
  localparam int FL_BANKS = 2;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic porRst = 1'b1;
  logic ce = 1'b1;
  logic bootSelSetCmd = 1'b0;
  logic bootSelClrCmd = 1'b0;
  logic erasePin = 1'b0;
  logic reqValid;
  logic [31:0] reqAddr;
  logic remapCmd;
  brd_route_s route;
  logic remapped;
  logic bootFromFlash;
  int bad_count = 0;
  int n_checks = 0;
  logic [31:0] fixedAddr [20] = '{32'h0000_0000, 32'h0000_FFFF, 32'h0001_0000, 32'h000F_FFFF, 32'h0010_0000,
    32'h0013_FFFC, 32'h0014_0000, 32'h0017_FFFF, 32'h0018_0000, 32'h0020_0000, 32'h0020_FFFF, 32'h0021_0000,
    32'h0030_0000, 32'h003F_FFFF, 32'h0040_0000, 32'hEFFF_FFFF, 32'hF000_0000, 32'hF000_4000, 32'hFFFF_EFFF,
    32'hFFFF_F000};

  always #25 sys_clk = ~sys_clk;

  brd_bus_master u_mst (.sys_clk(sys_clk), .reqValid(reqValid), .reqAddr(reqAddr), .remapCmd(remapCmd));

  brd_boot_remap_decoder #(.SRAM_KB(SRAM_KB), .FLASH_BANK_KB(FL_KB), .FLASH_BANKS(FL_BANKS)) dut (
    .sys_clk(sys_clk), .rst(rst), .porRst(porRst), .ce(ce), .reqValid(reqValid), .reqAddr(reqAddr),
    .remapCmd(remapCmd), .bootSelSetCmd(bootSelSetCmd), .bootSelClrCmd(bootSelClrCmd), .erasePin(erasePin),
    .route(route), .remapped(remapped), .bootFromFlash(bootFromFlash));

  // Reference map
  function automatic brd_route_s exp_route(input logic [31:0] a, input bit rm, input bit bf);
    brd_route_s r;
    longint sramSz;
    longint flSz;
    r = '0;
    r.valid = 1'b1;
    sramSz = SRAM_KB * 1024;
    flSz = FL_KB * 1024 * FL_BANKS;
    if (a >= BRD_SRAM_BASE && a < BRD_SRAM_BASE + sramSz)
    begin
      r.target = TGT_SRAM;
      r.offset = a - BRD_SRAM_BASE;
    end
    else if (a >= BRD_ROM_BASE && a < BRD_ROM_BASE + (1 << 20))
    begin
      r.target = TGT_ROM;
      r.offset = a - BRD_ROM_BASE;
    end
    else if (a >= BRD_FLASH_BASE && a < BRD_FLASH_BASE + flSz)
    begin
      r.target = TGT_FLASH;
      r.offset = a - BRD_FLASH_BASE;
    end
    else if (a >= BRD_PERIPH_LO && a <= BRD_PERIPH_HI)
    begin
      r.target = TGT_PERIPH;
      r.slot = a[27:14];
      r.offset = {18'h0, a[13:0]};
    end
    else if (rm && a < sramSz)
    begin
      r.target = TGT_SRAM;
      r.offset = a;
    end
    else if (!rm && bf && a < flSz)
    begin
      r.target = TGT_FLASH;
      r.offset = a;
    end
    else if (!rm && !bf && a < (1 << 20))
    begin
      r.target = TGT_ROM;
      r.offset = a;
    end
    if (r.target == TGT_FLASH && FL_BANKS == 2) r.flashBank = r.offset[18];
    return r;
  endfunction : exp_route

  task automatic chk_route(input brd_route_s e, input brd_route_s g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_route

  task automatic chk_bit(input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_bit

  task automatic rd(input logic [31:0] a, input bit rm, input bit bf);
    u_mst.read(a);
    @(negedge sys_clk);
    chk_route(exp_route(a, rm, bf), route);
  endtask : rd

  task automatic run_map(input bit rm, input bit bf);
    logic [31:0] a;
    foreach (fixedAddr[i]) rd(fixedAddr[i], rm, bf);
    repeat (16)
    begin
      case ($urandom % 4)
        0: a = $urandom & 32'h003F_FFFF;
        1: a = 32'hF000_0000 | $urandom;
        2: a = $urandom;
        default: a = $urandom & 32'h001F_FFFF;
      endcase
      rd(a, rm, bf);
    end
  endtask : run_map

  task automatic boot_cmd(input bit set);
    @(posedge sys_clk);
    if (set) bootSelSetCmd <= 1'b1;
    else bootSelClrCmd <= 1'b1;
    @(posedge sys_clk);
    bootSelSetCmd <= 1'b0;
    bootSelClrCmd <= 1'b0;
    @(negedge sys_clk);
  endtask : boot_cmd

  task automatic wrap_up();
    $display("Checks: %0d, mismatches: %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (4000) @(posedge sys_clk);
    bad_count++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'h67d8));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    porRst <= 1'b0;
    @(negedge sys_clk);
    chk_bit(1'b0, bootFromFlash);
    chk_bit(1'b0, remapped);
    run_map(1'b0, 1'b0);
    u_mst.release_bus();
    @(negedge sys_clk);
    chk_bit(1'b0, route.valid);
    boot_cmd(1'b1);
    chk_bit(1'b1, bootFromFlash);
    run_map(1'b0, 1'b1);
    boot_cmd(1'b0);
    chk_bit(1'b0, bootFromFlash);
    boot_cmd(1'b1);
    @(posedge sys_clk);
    erasePin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    erasePin <= 1'b0;
    @(negedge sys_clk);
    chk_bit(1'b0, bootFromFlash);
    rd(32'h0000_0100, 1'b0, 1'b0);
    boot_cmd(1'b1);
    u_mst.mc_write(BRD_REMAP_CTRL_OFFSET);
    @(negedge sys_clk);
    chk_bit(1'b1, remapped);
    run_map(1'b1, 1'b1);
    u_mst.mc_write(BRD_REMAP_CTRL_OFFSET);
    rd(32'h0000_0010, 1'b1, 1'b1);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk_route(brd_route_s'('0), route);
    chk_bit(1'b0, remapped);
    chk_bit(1'b1, bootFromFlash);
    rd(32'h0000_0040, 1'b0, 1'b1);
    @(posedge sys_clk);
    ce <= 1'b0;
    bootSelClrCmd <= 1'b1;
    u_mst.read(32'h0020_0000);
    @(negedge sys_clk);
    chk_route(exp_route(32'h0000_0040, 1'b0, 1'b1), route);
    chk_bit(1'b1, bootFromFlash);
    @(posedge sys_clk);
    ce <= 1'b1;
    bootSelClrCmd <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk_route(exp_route(32'h0020_0000, 1'b0, 1'b1), route);
    chk_bit(1'b1, bootFromFlash);
    wrap_up();
  end
endmodule : tb_brd_boot_remap_decoder
